// [design/fcsi_host.sv]
// Host controller that sequences command and status cycles on a parallel flash
`timescale 1ns/1ps
module fcsi_host #(
  parameter int ADDR_W = 19
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n_out,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  output logic reset_powerdown_n_out,
  input wire logic ready_busy_n_in
);
  if (ADDR_W < 11) begin : g_check
    $error("ADDR_W must cover the byte order bit");
  end

  fcsi_pkg::fcsi_phase_t phase;
  logic [3:0] op;
  logic [2:0] idx;
  logic [3:0] cnt;
  logic [ADDR_W-1:0] tgt_addr;
  logic [15:0] wr_data;
  logic rp_level;
  logic [7:0] dq_meta, dq_sync;
  logic rdy_meta, rdy_sync;
  logic [7:0] rd_byte, stat;
  logic pending_resume, prot_reset_done, locked_default, refused, suspend_req;
  logic [12:0] step;
  logic [2:0] kind;
  logic [ADDR_W-1:0] step_addr;
  logic [7:0] step_byte;
  logic cmd_wr, start, lock_bad, erase_op, susp_take, read_last, poll_ok, at_end;

  // ==========================================================
  // Operation programs
  localparam logic [12:0] S_END = {fcsi_pkg::K_END, fcsi_pkg::A_ZERO, fcsi_pkg::B_LOW};
  localparam logic [12:0] S_P = {fcsi_pkg::K_POLL, fcsi_pkg::A_ZERO, fcsi_pkg::B_LOW};
  localparam logic [12:0] S_R = {fcsi_pkg::K_RD, fcsi_pkg::A_TGT, fcsi_pkg::B_LOW};
  localparam logic [4:0] W0 = {fcsi_pkg::K_WR, fcsi_pkg::A_ZERO};
  function automatic logic [12:0] step_f(input logic [3:0] o, input logic [2:0] i);
    logic [12:0] s;
    case ({o, i})
      {fcsi_pkg::OP_READ_ARRAY, 3'h0}: s = {W0, fcsi_pkg::CMD_READ_ARRAY};
      {fcsi_pkg::OP_READ_ARRAY, 3'h1}: s = S_R;
      {fcsi_pkg::OP_READ_ID, 3'h0}: s = {W0, fcsi_pkg::CMD_READ_ID}; // R2
      {fcsi_pkg::OP_READ_ID, 3'h1}: s = S_R; // R1
      {fcsi_pkg::OP_READ_STATUS, 3'h0}: s = {W0, fcsi_pkg::CMD_READ_STATUS}; // R3
      {fcsi_pkg::OP_READ_STATUS, 3'h1}: s = S_P;
      {fcsi_pkg::OP_CLEAR_STATUS, 3'h0}: s = {W0, fcsi_pkg::CMD_CLEAR_STATUS}; // R5
      {fcsi_pkg::OP_WRITE, 3'h0}: s = {W0, fcsi_pkg::CMD_WORD_WRITE}; // R6
      {fcsi_pkg::OP_WRITE, 3'h1}: s = {fcsi_pkg::K_WRD, fcsi_pkg::A_TGT, fcsi_pkg::B_LOW};
      {fcsi_pkg::OP_WRITE, 3'h2}: s = S_P; // R4
      {fcsi_pkg::OP_ERASE, 3'h0}: s = {W0, fcsi_pkg::CMD_BLOCK_ERASE}; // R6
      {fcsi_pkg::OP_ERASE, 3'h1}: s = {fcsi_pkg::K_WR, fcsi_pkg::A_TGT, fcsi_pkg::CMD_CONFIRM};
      {fcsi_pkg::OP_ERASE, 3'h2}: s = S_P;
      {fcsi_pkg::OP_SUSPEND, 3'h0}: s = {W0, fcsi_pkg::CMD_SUSPEND}; // R7
      {fcsi_pkg::OP_SUSPEND, 3'h1}: s = S_P;
      {fcsi_pkg::OP_RESUME, 3'h0}: s = {W0, fcsi_pkg::CMD_CONFIRM}; // R7
      {fcsi_pkg::OP_RESUME, 3'h1}: s = S_P;
      {fcsi_pkg::OP_PROT_SET, 3'h0}: s = {W0, fcsi_pkg::CMD_PROTECT_SET}; // R9
      {fcsi_pkg::OP_PROT_SET, 3'h1}: s = {fcsi_pkg::K_WR, fcsi_pkg::A_CFM, fcsi_pkg::CMD_CONFIRM};
      {fcsi_pkg::OP_PROT_SET, 3'h2}: s = S_P;
      {fcsi_pkg::OP_PROT_RESET, 3'h0}: s = {W0, fcsi_pkg::CMD_PROTECT_RESET}; // R11
      {fcsi_pkg::OP_PROT_RESET, 3'h1}: s = {fcsi_pkg::K_WR, fcsi_pkg::A_CFM, fcsi_pkg::CMD_CONFIRM};
      {fcsi_pkg::OP_PROT_RESET, 3'h2}: s = S_P;
      {fcsi_pkg::OP_LOCK, 3'h0}: s = {W0, fcsi_pkg::CMD_LOCK_BLOCK}; // R12
      {fcsi_pkg::OP_LOCK, 3'h1}: s = {fcsi_pkg::K_WR, fcsi_pkg::A_TGT, fcsi_pkg::CMD_CONFIRM};
      {fcsi_pkg::OP_LOCK, 3'h2}: s = S_P;
      {fcsi_pkg::OP_LOCK, 3'h3}: s = {W0, fcsi_pkg::CMD_PROTECT_SET}; // R12
      {fcsi_pkg::OP_LOCK, 3'h4}: s = {fcsi_pkg::K_WR, fcsi_pkg::A_CFM, fcsi_pkg::CMD_CONFIRM};
      {fcsi_pkg::OP_LOCK, 3'h5}: s = S_P;
      {fcsi_pkg::OP_ERASE_ALL, 3'h0}: s = {W0, fcsi_pkg::CMD_ERASE_ALL}; // R13
      {fcsi_pkg::OP_ERASE_ALL, 3'h1}: s = {W0, fcsi_pkg::CMD_CONFIRM};
      {fcsi_pkg::OP_ERASE_ALL, 3'h2}: s = S_P;
      {fcsi_pkg::OP_TWO_BYTE, 3'h0}: s = {W0, fcsi_pkg::CMD_TWO_BYTE}; // R14
      {fcsi_pkg::OP_TWO_BYTE, 3'h1}: s = {fcsi_pkg::K_WRD, fcsi_pkg::A_TGT, fcsi_pkg::B_FIRST};
      {fcsi_pkg::OP_TWO_BYTE, 3'h2}: s = {fcsi_pkg::K_WRD, fcsi_pkg::A_TGT, fcsi_pkg::B_SECOND};
      {fcsi_pkg::OP_TWO_BYTE, 3'h3}: s = S_P;
      default: s = S_END;
    endcase
    return s;
  endfunction

  // ==========================================================
  // Decode
  always_comb begin
    step = step_f(op, idx);
    kind = step[12:10];
    case (step[9:8])
      fcsi_pkg::A_TGT: step_addr = tgt_addr;
      fcsi_pkg::A_CFM: step_addr = {{(ADDR_W - 10){1'b0}}, fcsi_pkg::CONFIRM_ADDR}; // R15
      default: step_addr = '0;
    endcase
    // Order bit low sends the low byte first; second byte takes the other half
    if ((step[7:0] == fcsi_pkg::B_FIRST && tgt_addr[fcsi_pkg::ORDER_BIT]) ||
        (step[7:0] == fcsi_pkg::B_SECOND && !tgt_addr[fcsi_pkg::ORDER_BIT])) begin // R14
      step_byte = wr_data[15:8];
    end else begin
      step_byte = wr_data[7:0];
    end
  end

  assign cmd_wr = reg_wr_in && reg_addr_in == fcsi_pkg::REG_CMD;
  assign erase_op = op == fcsi_pkg::OP_ERASE || op == fcsi_pkg::OP_ERASE_ALL;
  assign lock_bad = reg_wdata_in[3:0] == fcsi_pkg::OP_LOCK && !prot_reset_done; // R12
  // Busy device takes only the suspend, and only while an erase runs
  assign start = cmd_wr && phase == fcsi_pkg::PH_IDLE && rp_level && !lock_bad; // R24
  assign susp_take = cmd_wr && phase != fcsi_pkg::PH_IDLE && erase_op &&
                     reg_wdata_in[3:0] == fcsi_pkg::OP_SUSPEND; // R24
  assign read_last = phase == fcsi_pkg::PH_RSTB && cnt == 4'h1;
  assign poll_ok = dq_sync[fcsi_pkg::ST_READY] && rdy_sync; // R19
  assign at_end = phase == fcsi_pkg::PH_FETCH && kind == fcsi_pkg::K_END;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
      rdy_meta <= ready_busy_n_in;
      rdy_sync <= rdy_meta; // R21
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      tgt_addr <= '0;
      wr_data <= 16'h0000;
      rp_level <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == fcsi_pkg::REG_ADDR) tgt_addr <= reg_wdata_in[ADDR_W-1:0];
      if (reg_addr_in == fcsi_pkg::REG_DATA) wr_data <= reg_wdata_in[15:0];
      if (reg_addr_in == fcsi_pkg::REG_CTRL) rp_level <= reg_wdata_in[0];
    end
  end
  assign reset_powerdown_n_out = rp_level;

  // ==========================================================
  // Bus cycle sequencer
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || !rp_level) begin // R22
      phase <= fcsi_pkg::PH_IDLE;
      op <= fcsi_pkg::OP_READ_ARRAY;
      idx <= 3'h0;
      cnt <= 4'h0;
      flash_addr_out <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe_n_out <= 1'b1;
      flash_ce_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
    end else begin
      unique case (phase)
        fcsi_pkg::PH_IDLE: begin
          if (start) begin
            op <= reg_wdata_in[3:0];
            idx <= 3'h0;
            phase <= fcsi_pkg::PH_FETCH;
          end
        end
        fcsi_pkg::PH_FETCH: begin
          flash_addr_out <= step_addr;
          if (kind == fcsi_pkg::K_WR || kind == fcsi_pkg::K_WRD) begin
            flash_dq_out <= kind == fcsi_pkg::K_WR ? step[7:0] : step_byte;
            flash_dq_oe_n_out <= 1'b0;
            flash_ce_n_out <= 1'b0;
            phase <= fcsi_pkg::PH_WSET;
          end else if (kind == fcsi_pkg::K_RD || kind == fcsi_pkg::K_POLL) begin
            flash_ce_n_out <= 1'b0;
            flash_oe_n_out <= 1'b0;
            cnt <= fcsi_pkg::RD_CYC;
            phase <= fcsi_pkg::PH_RSTB;
          end else if (erase_op && pending_resume) begin // R8
            op <= fcsi_pkg::OP_RESUME;
            idx <= 3'h0;
          end else begin
            phase <= fcsi_pkg::PH_IDLE;
          end
        end
        fcsi_pkg::PH_WSET: begin
          flash_we_n_out <= 1'b0;
          cnt <= fcsi_pkg::WE_CYC;
          phase <= fcsi_pkg::PH_WSTB;
        end
        fcsi_pkg::PH_WSTB: begin
          if (cnt == 4'h1) begin
            flash_we_n_out <= 1'b1;
            phase <= fcsi_pkg::PH_WHOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        fcsi_pkg::PH_WHOLD: begin
          // Data held one cycle past the rising write strobe
          flash_ce_n_out <= 1'b1;
          flash_dq_oe_n_out <= 1'b1;
          idx <= idx + 3'h1;
          phase <= fcsi_pkg::PH_FETCH;
        end
        fcsi_pkg::PH_RSTB: begin
          if (cnt == 4'h1) begin
            flash_ce_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            phase <= fcsi_pkg::PH_FETCH;
            if (kind == fcsi_pkg::K_RD || poll_ok) begin // R19
              idx <= idx + 3'h1;
            end else if (suspend_req && erase_op) begin // R7
              op <= fcsi_pkg::OP_SUSPEND;
              idx <= 3'h0;
            end
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: phase <= fcsi_pkg::PH_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Results and protection tracking
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rd_byte <= 8'h00;
      stat <= 8'h00;
      pending_resume <= 1'b0;
      prot_reset_done <= 1'b0;
      locked_default <= 1'b1;
      refused <= 1'b0;
      suspend_req <= 1'b0;
    end else begin
      if (read_last && kind == fcsi_pkg::K_RD) rd_byte <= dq_sync;
      if (read_last && kind == fcsi_pkg::K_POLL) stat <= dq_sync & fcsi_pkg::STAT_MASK; // R20
      if (!rp_level) begin
        // Device forgets protect state and clears its status when held down
        locked_default <= 1'b1; // R10
        prot_reset_done <= 1'b0;
        stat <= 8'h00; // R22
        suspend_req <= 1'b0;
      end else if (at_end) begin
        if (op == fcsi_pkg::OP_PROT_RESET) prot_reset_done <= 1'b1; // R11
        if (op == fcsi_pkg::OP_PROT_SET || op == fcsi_pkg::OP_LOCK) begin
          prot_reset_done <= 1'b0;
          locked_default <= 1'b0; // R9
        end
        if (op == fcsi_pkg::OP_SUSPEND && !stat[fcsi_pkg::ST_SUSPENDED]) begin
          pending_resume <= 1'b1; // R8
        end else if (erase_op) begin
          pending_resume <= 1'b0;
        end
      end
      if (susp_take) begin
        suspend_req <= 1'b1;
      end else if (phase == fcsi_pkg::PH_IDLE || op == fcsi_pkg::OP_SUSPEND) begin
        suspend_req <= 1'b0;
      end
      if (cmd_wr && !start && !susp_take) begin
        refused <= 1'b1;
      end else if (start) begin
        refused <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register readback, one cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        fcsi_pkg::REG_ADDR: reg_rdata_out <= 32'(tgt_addr);
        fcsi_pkg::REG_DATA: reg_rdata_out <= {16'h0000, wr_data};
        fcsi_pkg::REG_RESULT: reg_rdata_out <= {16'h0000, stat, rd_byte};
        fcsi_pkg::REG_STATE: reg_rdata_out <= {26'h0, locked_default, prot_reset_done,
                                               refused, pending_resume, rdy_sync,
                                               phase != fcsi_pkg::PH_IDLE};
        fcsi_pkg::REG_CTRL: reg_rdata_out <= {31'h0, rp_level};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_we_pulse;
    !flash_we_n_out [*2] ##1 flash_we_n_out;
  endsequence
  sequence s_read_pulse;
    !flash_oe_n_out [*6] ##1 flash_oe_n_out;
  endsequence

  a_we_pulse_width: assert property ($fell(flash_we_n_out) |-> s_we_pulse) // R6
    else $error("write strobe width wrong");
  a_read_access: assert property ($fell(flash_oe_n_out) |-> s_read_pulse) // R19
    else $error("read strobe too short");
  a_write_drives_dq: assert property (!flash_we_n_out |-> !flash_dq_oe_n_out && !flash_ce_n_out
                                      && flash_oe_n_out) // R6
    else $error("write strobe without data drive");
  a_confirm_address: assert property ($fell(flash_we_n_out) && flash_dq_out == fcsi_pkg::CMD_CONFIRM
      && (op == fcsi_pkg::OP_PROT_SET || op == fcsi_pkg::OP_PROT_RESET) |->
      flash_addr_out[9:0] == fcsi_pkg::CONFIRM_ADDR) // R15
    else $error("confirm address malformed");
  a_powerdown_abort: assert property (!rp_level |=> phase == fcsi_pkg::PH_IDLE && flash_ce_n_out
                                      && flash_we_n_out && stat == 8'h00) // R22
    else $error("power-down did not abort");
  a_status_masked: assert property (read_last && kind == fcsi_pkg::K_POLL && rp_level |=>
      stat[2:0] == 3'h0 && stat[7:3] == $past(dq_sync[7:3])) // R20
    else $error("status capture wrong");
  a_poll_waits: assert property (read_last && kind == fcsi_pkg::K_POLL && !poll_ok && rp_level
      && !suspend_req |=> idx == $past(idx)) // R19
    else $error("poll advanced while busy");
  a_lock_refused: assert property (cmd_wr && lock_bad && phase == fcsi_pkg::PH_IDLE |=>
      refused && phase == fcsi_pkg::PH_IDLE) // R12
    else $error("lock accepted before protect reset");
  a_resume_pending: assert property (at_end && rp_level && op == fcsi_pkg::OP_SUSPEND &&
      !stat[fcsi_pkg::ST_SUSPENDED] |=> pending_resume) // R8
    else $error("missed resume not recorded");
  a_busy_refuses: assert property (cmd_wr && phase != fcsi_pkg::PH_IDLE && rp_level && !susp_take
      |=> op == $past(op) || phase == fcsi_pkg::PH_IDLE) // R24
    else $error("command taken while busy");
endmodule

// [design/fcsi_pkg.sv]
// Constants, codes and register map of the flash command/status host controller
// Notes on behaviour
// R1: Identifier reads return maker code with address bit 0 low, part code high.
// R2: Host writes 90H to enter identifier mode, then reads the signatures.
// R3: After 70H any read returns the compatible status register.
// R4: Data write, erase and suspend switch reads to status automatically.
// R5: One 50H write clears status bits 3, 4 and 5 only.
// R6: Data write is 40H then data; block erase is 20H then D0H in block.
// R7: B0H suspends an erase, D0H resumes; host checks suspended bit first.
// R8: If suspend found no erase, host resumes after the next erase completes.
// R9: Protect set is 57H then D0H at the confirm address.
// R10: After power-up or power-down every block acts locked until protect set.
// R11: Protect reset (47H, D0H at confirm address) unlocks every block.
// R12: Lock block (77H, D0H) only after protect reset, then protect set again.
// R13: Erase-all-unlocked (A7H, D0H) erases blocks whose stored lock is clear.
// R14: Two-byte write FBH, first byte with order bit, second byte at target.
// R15: Confirm address has bits 9 and 8 low and bits 7 to 0 high.
// R16: Status bit 7 ready, 6 suspended, 5 erase error, 4 write error, 3 supply.
// R17: Improper erase sequence sets write error and erase error together.
// R18: Supply-low bit is sampled only when a write or erase is entered.
// R19: Host waits for ready pin or ready bit before reading result bits; the host here waits for both.
// R20: Host masks reserved status bits 2 to 0 when polling.
// R21: Ready/busy pin is held low while the write machine runs.
// R22: Reset/power-down low aborts operations and clears the status register.
// R23: Status stays on reads until the host writes FFH.
// R24: While busy, only status read and erase suspend are accepted; the host here takes only the erase suspend.
package fcsi_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 25;
  localparam int T_ACC_NS = 80;
  localparam int T_WE_NS = 50;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] RD_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [3:0] WE_CYC = 4'((T_WE_NS + CLK_NS - 1) / CLK_NS);
  // ==========================================================
  // Device command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_WRITE = 8'h40;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_PROTECT_SET = 8'h57;
  localparam logic [7:0] CMD_PROTECT_RESET = 8'h47;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h77;
  localparam logic [7:0] CMD_ERASE_ALL = 8'ha7;
  localparam logic [7:0] CMD_TWO_BYTE = 8'hfb;
  localparam logic [9:0] CONFIRM_ADDR = 10'h0ff;
  localparam int ORDER_BIT = 10;
  // ==========================================================
  // Status layout
  localparam int ST_READY = 7;
  localparam int ST_SUSPENDED = 6;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_WRITE_ERR = 4;
  localparam int ST_SUPPLY_LOW = 3;
  localparam logic [7:0] STAT_MASK = 8'hf8;
  // ==========================================================
  // Host operations
  localparam logic [3:0] OP_READ_ARRAY = 4'h0;
  localparam logic [3:0] OP_READ_ID = 4'h1;
  localparam logic [3:0] OP_READ_STATUS = 4'h2;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
  localparam logic [3:0] OP_WRITE = 4'h4;
  localparam logic [3:0] OP_ERASE = 4'h5;
  localparam logic [3:0] OP_SUSPEND = 4'h6;
  localparam logic [3:0] OP_RESUME = 4'h7;
  localparam logic [3:0] OP_PROT_SET = 4'h8;
  localparam logic [3:0] OP_PROT_RESET = 4'h9;
  localparam logic [3:0] OP_LOCK = 4'ha;
  localparam logic [3:0] OP_ERASE_ALL = 4'hb;
  localparam logic [3:0] OP_TWO_BYTE = 4'hc;
  // Step kinds, address and byte selects
  localparam logic [2:0] K_WR = 3'h0;
  localparam logic [2:0] K_WRD = 3'h1;
  localparam logic [2:0] K_RD = 3'h2;
  localparam logic [2:0] K_POLL = 3'h3;
  localparam logic [2:0] K_END = 3'h4;
  localparam logic [1:0] A_ZERO = 2'h0;
  localparam logic [1:0] A_TGT = 2'h1;
  localparam logic [1:0] A_CFM = 2'h2;
  localparam logic [7:0] B_LOW = 8'h00;
  localparam logic [7:0] B_FIRST = 8'h01;
  localparam logic [7:0] B_SECOND = 8'h02;
  // ==========================================================
  // Register map
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_RESULT = 5'h0c;
  localparam logic [4:0] REG_STATE = 5'h10;
  localparam logic [4:0] REG_CTRL = 5'h14;
  localparam logic [7:0] NO_READ = 8'h00;

  typedef enum logic [6:0] {
    PH_IDLE = 7'b0000001,
    PH_FETCH = 7'b0000010,
    PH_WSET = 7'b0000100,
    PH_WSTB = 7'b0001000,
    PH_WHOLD = 7'b0010000,
    PH_RSTB = 7'b0100000,
    PH_SPARE = 7'b1000000
  } fcsi_phase_t;
endpackage

// [tb/fcsi_flash_model.sv]
// Behavioural model of the byte-wide flash device facing the host controller
`timescale 1ns/1ps
module fcsi_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h3c // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic [18:0] addr_in,
  input wire logic [7:0] dq_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic rp_n_in,
  output logic [7:0] dq_out,
  output logic ready_busy_n_out
);
  // ==========================================================
  // State; busy times are short so a run stays brief
  logic [7:0] mem [0:524287];
  logic [31:0] lock_bits = '0;
  logic [7:0] stat = 8'h80, cmd = 8'hff, first = '0, last = '0, rd;
  logic lk_def = 1'b1, unprot = 1'b0, erasing = 1'b0;
  int busy = 0, rem = 0, mode = 0, step = 0;
  initial for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
  function automatic logic locked(input logic [18:0] a);
    return lk_def || (!unprot && lock_bits[a[18:14]]);
  endfunction
  task automatic go(input int n);
    busy = n;
    stat[7] = 1'b0;
    mode = 2;
  endtask
  task automatic wipe(input int b);
    for (int i = 0; i < 16384; i++) mem[b * 16384 + i] = 8'hff;
  endtask
  // ==========================================================
  // Command decoder, taken at the rising write strobe
  always @(posedge we_n_in) begin
    if (!ce_n_in && rp_n_in) begin
      if (busy > 0) begin
        if (dq_in == 8'hb0 && erasing) begin
          rem = busy;
          busy = 0;
          stat = stat | 8'hc0;
        end
      end else if (step == 0) begin
        cmd = dq_in;
        step = 1;
        case (dq_in)
          8'hff: mode = 0;
          8'h90: mode = 1;
          8'h70: mode = 2;
          8'h50: stat = stat & 8'hc7;
          8'hd0: if (stat[6]) begin
            stat[6] = 1'b0;
            go(rem);
          end
          default: mode = 2;
        endcase
        if (dq_in inside {8'hff, 8'h90, 8'h70, 8'h50, 8'hb0, 8'hd0}) step = 0;
      end else if (cmd == 8'hfb && step == 1) begin
        first = dq_in;
        step = 2;
      end else begin
        step = 0;
        go(6);
        if (cmd inside {8'h20, 8'h57, 8'h47, 8'h77, 8'ha7} && dq_in != 8'hd0) begin
          stat = stat | 8'h30;
        end else if (cmd == 8'h57 || cmd == 8'h47) begin
          if (addr_in[9:0] == 10'h0ff) begin
            lk_def = 1'b0;
            unprot = (cmd == 8'h47);
          end
        end else if (cmd == 8'h77) begin
          lock_bits[addr_in[18:14]] = 1'b1;
        end else if (cmd == 8'ha7) begin
          for (int b = 0; b < 32; b++) if (!lock_bits[b]) wipe(b);
          erasing = 1'b1;
          go(300);
        end else if (locked(addr_in)) begin
          stat = stat | 8'h30;
        end else if (cmd == 8'h20) begin
          wipe(addr_in[18:14]);
          erasing = 1'b1;
          go(300);
        end else if (cmd == 8'hfb) begin
          mem[addr_in] = first;
          mem[addr_in ^ 19'h400] = dq_in;
        end else begin
          mem[addr_in] = dq_in;
        end
      end
    end
  end
  always @(posedge clk_in) begin
    if (busy == 1) begin
      stat[7] = 1'b1;
      erasing = 1'b0;
    end
    if (busy > 0) busy--;
  end
  // Deep power-down forgets the protect state as well
  always @(negedge rp_n_in) begin
    busy = 0;
    stat = 8'h80;
    {mode, step} = '0;
    {lk_def, unprot, erasing} = 3'b100;
  end
  always @* begin
    if (mode == 1) rd = (addr_in[18:1] != '0) ? 8'h00 : (addr_in[0] ? PART_ID : MAKER_ID);
    else if (mode == 2) rd = stat;
    else rd = mem[addr_in];
  end
  // Released bus shows the inverse, so a stale capture cannot pass
  always @(posedge oe_n_in) last = rd;
  assign dq_out = (!ce_n_in && !oe_n_in && rp_n_in) ? rd : ~last;
  assign ready_busy_n_out = (busy == 0) || !rp_n_in;
endmodule

// [tb/testbench.sv]
// Self-checking bench for the flash host controller against the device model
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Clock, wiring and bench memory model
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART = 8'h3c; // Arbitrary value
  logic sys_clk = 1'b0, resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [4:0] addr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [18:0] faddr;
  logic [7:0] hdq, ddq, dq;
  logic dq_oe_n, ce_n, oe_n, we_n, rp_n, rb_n;
  int n_mismatch = 0, n_compared = 0, seed = 37127, a;
  logic [15:0] d;
  logic [7:0] em [int];
  int blk [$];
  assign dq = dq_oe_n ? ddq : hdq;
  always #12.5 sys_clk = ~sys_clk;
  fcsi_host i_dut (.sys_clk_in(sys_clk), .resetn_in(resetn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .flash_addr_out(faddr), .flash_dq_out(hdq), .flash_dq_oe_n_out(dq_oe_n),
    .flash_dq_in(dq), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
    .flash_we_n_out(we_n), .reset_powerdown_n_out(rp_n), .ready_busy_n_in(rb_n));
  fcsi_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_flash (.clk_in(sys_clk),
    .addr_in(faddr), .dq_in(dq), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .rp_n_in(rp_n), .dq_out(ddq), .ready_busy_n_out(rb_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [31:0] rd_v);
    @(posedge sys_clk);
    addr <= ra;
    wdata <= rd_v;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] ra);
    @(posedge sys_clk);
    addr <= ra;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic op(input logic [3:0] o);
    wr(fcsi_pkg::REG_CMD, 32'(o));
    for (int i = 0; i < 3000; i++) begin
      rd(fcsi_pkg::REG_STATE);
      if (v[0] === 1'b0) break;
    end
    chk(32'(v[0]), 32'h0, "operation finished");
  endtask
  task automatic run(input logic [3:0] o, input int ra, input logic [15:0] dd);
    wr(fcsi_pkg::REG_ADDR, 32'(ra));
    wr(fcsi_pkg::REG_DATA, 32'(dd));
    op(o);
    rd(fcsi_pkg::REG_RESULT);
  endtask
  function automatic logic [7:0] ex(input int ra);
    return em.exists(ra) ? em[ra] : 8'hff;
  endfunction
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test;
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    wr(fcsi_pkg::REG_CMD, 32'(fcsi_pkg::OP_READ_ARRAY));
    rd(fcsi_pkg::REG_STATE);
    chk(v, 32'h2a, "held in power-down");
    rd(5'h18);
    chk(v, 32'h0, "unmapped read");
    wr(fcsi_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      run(fcsi_pkg::OP_READ_ID, i, 0);
      chk(v[7:0], i == 0 ? MAKER : (i == 1 ? PART : 8'h00), "identifier");
    end
    $display("test identifier done");
    run(fcsi_pkg::OP_WRITE, 'h123, 16'h55);
    chk(v[15:8], 8'hb0, "write while locked");
    run(fcsi_pkg::OP_CLEAR_STATUS, 0, 0);
    run(fcsi_pkg::OP_READ_STATUS, 0, 0);
    chk(v[15:8], 8'h80, "cleared status");
    run(fcsi_pkg::OP_PROT_RESET, 0, 0);
    for (int i = 1; i < 5; i++) begin
      a = {5'(i), 14'($random(seed))};
      d = 16'($random(seed));
      blk.push_back(a);
      em[a] = d[7:0];
      run(fcsi_pkg::OP_WRITE, a, d);
      chk(v[15:8], 8'h80, "write status");
      run(fcsi_pkg::OP_READ_ARRAY, a, 0);
      chk(v[7:0], ex(a), "array read");
    end
    $display("test protect and write done");
    run(fcsi_pkg::OP_LOCK, blk[2], 0);
    run(fcsi_pkg::OP_WRITE, blk[2], 16'h00);
    chk(v[15:8], 8'hb0, "write to locked block");
    run(fcsi_pkg::OP_CLEAR_STATUS, 0, 0);
    for (int j = 0; j < 2; j++) begin
      a = 'h2000 + j * 'h400;
      d = 16'($random(seed));
      em[a] = j ? d[15:8] : d[7:0];
      em[a ^ 'h400] = j ? d[7:0] : d[15:8];
      run(fcsi_pkg::OP_TWO_BYTE, a, d);
      run(fcsi_pkg::OP_READ_ARRAY, a, 0);
      chk(v[7:0], ex(a), "first byte");
      run(fcsi_pkg::OP_READ_ARRAY, a ^ 'h400, 0);
      chk(v[7:0], ex(a ^ 'h400), "second byte");
    end
    wr(fcsi_pkg::REG_ADDR, 32'(blk[0]));
    wr(fcsi_pkg::REG_CMD, 32'(fcsi_pkg::OP_ERASE));
    op(fcsi_pkg::OP_SUSPEND);
    rd(fcsi_pkg::REG_RESULT);
    chk(v[15:8], 8'hc0, "suspended");
    run(fcsi_pkg::OP_RESUME, 0, 0);
    chk(v[15:8], 8'h80, "resumed");
    em.delete(blk[0]);
    run(fcsi_pkg::OP_READ_ARRAY, blk[0], 0);
    chk(v[7:0], ex(blk[0]), "erased block");
    d = 16'(em[blk[2]]);
    em.delete();
    em[blk[2]] = d[7:0];
    run(fcsi_pkg::OP_ERASE_ALL, 0, 0);
    foreach (blk[k]) begin
      run(fcsi_pkg::OP_READ_ARRAY, blk[k], 0);
      chk(v[7:0], ex(blk[k]), "erase unlocked");
    end
    $display("test erase done");
    wr(fcsi_pkg::REG_CTRL, 32'h0);
    rd(fcsi_pkg::REG_STATE);
    chk(v, 32'h22, "power-down state");
    end_of_test;
  end
endmodule
